// ===== rtl/rpt_defs.vh
// Purpose: register map, field positions and reset values of the rgb panel timing block
// Assumes: 32-bit axi4-lite data, one aligned word per register
// Notes: timing counts are in dot periods or lines
`ifndef RPT_DEFS_VH
`define RPT_DEFS_VH

// register byte offsets
`define RPT_CTRL_OFS 8'h00
`define RPT_HSW_OFS 8'h04
`define RPT_HBP_OFS 8'h08
`define RPT_HACT_OFS 8'h0C
`define RPT_HFP_OFS 8'h10
`define RPT_VSW_OFS 8'h14
`define RPT_VBP_OFS 8'h18
`define RPT_VACT_OFS 8'h1C
`define RPT_VFP_OFS 8'h20
`define RPT_VEXTRA_OFS 8'h24
`define RPT_DIV_OFS 8'h28
`define RPT_STATUS_OFS 8'h2C

// control fields
`define RPT_CTRL_RUN 0
`define RPT_CTRL_INVERT 1
`define RPT_CTRL_DE_USE 2
`define RPT_CTRL_W 3
`define RPT_CTRL_RST 3'h4

// status fields
`define RPT_ST_ACTIVE 16
`define RPT_ST_UNDERFLOW 17

// field widths
`define RPT_CNT_W 12
`define RPT_DIV_W 8

// reset values of timing counts
`define RPT_HSW_RST 12'h002
`define RPT_HBP_RST 12'h002
`define RPT_HACT_RST 12'h140
`define RPT_HFP_RST 12'h002
`define RPT_VSW_RST 12'h001
`define RPT_VBP_RST 12'h002
`define RPT_VACT_RST 12'h0F0
`define RPT_VFP_RST 12'h002
`define RPT_VEXTRA_RST 12'h000
`define RPT_DIV_RST 8'h00

// axi response codes
`define RPT_RESP_OKAY 2'h0
`define RPT_RESP_SLVERR 2'h2

`endif

// ===== rtl/rpt_top.v
// Purpose: timing and pixel stream generator for a parallel rgb tft panel
// Assumes: aclk 25 MHz, synchronous active-low reset, axi4-lite register access
// Notes: dot clock is divided from aclk, so there is a single clock domain
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "rpt_defs.vh"

// pixel buffer between the source and the panel timing
module rpt_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    input wire ce,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr, rd_ptr;
    reg [AW:0] count;
    wire push, pop;

    // honest full and empty from the fill count
    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // storage array, no reset needed
    always @(posedge aclk) begin
        if (ce && push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and fill count
    always @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // rpt_fifo

// Overview of operation
// [RL1] one stable pixel word presented per dot clock latch edge, rising by default
// [RL2] line sync period covers sync, back porch, active pixels and front porch
// [RL3] frame sync period covers all active and blanking lines
// [RL4] frame timing programmable to reach frame rates between 30 and 80 Hz
// [RL5] data enable high only while a valid pixel is on the colour bus
// [RL6] panel may locate pixels by fixed back porch if enable held active
// [RL7] pixel word carries red 15:11, green 10:5, blue 4:0
// [RL8] colour fields feed the most significant panel inputs; lower inputs undriven
// [RL9] data enable optional; timing correct without it
// [RL10] read-only frame counter and transfer active flag
// [RL11] control bit moves data launch so panel latches on falling edge
// [RL12] lower frame rate by extra vertical blanking lines, active timing unchanged
// [RL13] separate dot clock divider during blanking and during active pixels
// [RL14] end of each active line pulses the fetch trigger for the next line
// [RL15] programmable front porch, sync, back porch, active counts for both axes
// [RL16] reset drops syncs and enable, clears frame count, restarts at frame start
module rpt_top #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3
) (
    // clock, reset, clock enable
    input wire aclk,
    input wire aresetn,
    input wire ce,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // pixel source stream, rgb565
    input wire [15:0] pixel_in_data,
    input wire pixel_in_valid,
    output wire pixel_in_ready,
    // panel pins
    output reg dot_clk_out,
    output reg line_sync_pin,
    output reg frame_sync_pin,
    output reg pixel_valid_out,
    output reg line_valid_out,
    output reg [15:0] pixel_data_out,
    // fetch request and status
    output reg line_fetch_trigger,
    output wire transfer_active_flag,
    output reg [15:0] frame_count
);
    // configuration registers
    reg [`RPT_CTRL_W-1:0] ctrl;
    reg [`RPT_CNT_W-1:0] hsw, hbp, hact, hfp;
    reg [`RPT_CNT_W-1:0] vsw, vbp, vact, vfp, vextra;
    reg [`RPT_DIV_W-1:0] active_dot_rate, blank_dot_rate;
    reg underflow;

    // axi holding state
    reg aw_held, w_held;
    reg [7:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    wire wr_go, rd_go;
    wire [31:0] bmask;
    reg [31:0] rd_word;
    reg rd_hit, wr_hit;

    // timing state
    reg [13:0] h_cnt, v_cnt;
    reg [`RPT_DIV_W-1:0] half_cnt;
    reg v_act_q;
    wire run;
    wire [13:0] h_act_start, h_act_end, h_last;
    wire [13:0] v_act_start, v_act_end, v_last;
    wire h_act, v_act, pos_act;
    wire half_hit, dot_tick;
    wire [`RPT_DIV_W-1:0] cur_div;
    wire fifo_valid, pop_req;
    wire [15:0] fifo_data;

    assign run = ctrl[`RPT_CTRL_RUN];

    // bus handshakes: address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = aw_held && w_held && !s_axi_bvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign bmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

    // line and frame boundaries, sync then back porch then active then front porch
    assign h_act_start = {2'b00, hsw} + {2'b00, hbp}; // RL2 RL15
    assign h_act_end = h_act_start + {2'b00, hact};
    assign h_last = h_act_end + {2'b00, hfp} - 14'h0001; // RL2
    assign v_act_start = {2'b00, vsw} + {2'b00, vbp}; // RL15
    assign v_act_end = v_act_start + {2'b00, vact};
    assign v_last = v_act_end + {2'b00, vfp} + {2'b00, vextra} - 14'h0001; // RL3 RL12
    assign h_act = (h_cnt >= h_act_start) && (h_cnt < h_act_end);
    assign v_act = (v_cnt >= v_act_start) && (v_cnt < v_act_end);
    assign pos_act = h_act && v_act;

    // divider follows the pixel on the bus, so each pixel gets full active periods
    assign cur_div = line_valid_out ? active_dot_rate : blank_dot_rate; // RL13
    assign half_hit = run && (half_cnt == cur_div);
    // launch edge is the latch edge itself, rising unless invert is set
    assign dot_tick = half_hit && (dot_clk_out == ctrl[`RPT_CTRL_INVERT]); // RL1 RL11
    assign pop_req = dot_tick && pos_act;
    assign transfer_active_flag = run && v_act_q; // RL10

    // pixel buffer in the data path
    rpt_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .in_valid(pixel_in_valid), .in_ready(pixel_in_ready), .in_data(pixel_in_data),
        .out_valid(fifo_valid), .out_ready(pop_req), .out_data(fifo_data)
    );

    // address decode for writes
    always @* begin
        case (aw_addr_q)
            `RPT_CTRL_OFS, `RPT_HSW_OFS, `RPT_HBP_OFS, `RPT_HACT_OFS, `RPT_HFP_OFS,
            `RPT_VSW_OFS, `RPT_VBP_OFS, `RPT_VACT_OFS, `RPT_VFP_OFS, `RPT_VEXTRA_OFS,
            `RPT_DIV_OFS, `RPT_STATUS_OFS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // read mux, unmapped reads return zero
    always @* begin
        rd_hit = 1'b1;
        rd_word = 32'h00000000;
        case (s_axi_araddr)
            `RPT_CTRL_OFS: rd_word = {29'h00000000, ctrl};
            `RPT_HSW_OFS: rd_word = {20'h00000, hsw};
            `RPT_HBP_OFS: rd_word = {20'h00000, hbp};
            `RPT_HACT_OFS: rd_word = {20'h00000, hact};
            `RPT_HFP_OFS: rd_word = {20'h00000, hfp};
            `RPT_VSW_OFS: rd_word = {20'h00000, vsw};
            `RPT_VBP_OFS: rd_word = {20'h00000, vbp};
            `RPT_VACT_OFS: rd_word = {20'h00000, vact};
            `RPT_VFP_OFS: rd_word = {20'h00000, vfp};
            `RPT_VEXTRA_OFS: rd_word = {20'h00000, vextra};
            `RPT_DIV_OFS: rd_word = {16'h0000, blank_dot_rate, active_dot_rate};
            `RPT_STATUS_OFS: rd_word = {14'h0000, underflow, transfer_active_flag,
                frame_count}; // RL10
            default: rd_hit = 1'b0;
        endcase
    end

    // write channel capture and response
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RPT_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `RPT_RESP_OKAY : `RPT_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel, answer one cycle after the address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RPT_RESP_OKAY;
        end else if (ce) begin
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `RPT_RESP_OKAY : `RPT_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // configuration registers with byte strobes
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `RPT_CTRL_RST;
            hsw <= `RPT_HSW_RST;
            hbp <= `RPT_HBP_RST;
            hact <= `RPT_HACT_RST;
            hfp <= `RPT_HFP_RST;
            vsw <= `RPT_VSW_RST;
            vbp <= `RPT_VBP_RST;
            vact <= `RPT_VACT_RST;
            vfp <= `RPT_VFP_RST;
            vextra <= `RPT_VEXTRA_RST;
            active_dot_rate <= `RPT_DIV_RST;
            blank_dot_rate <= `RPT_DIV_RST;
        end else if (ce && wr_go) begin
            case (aw_addr_q)
                `RPT_CTRL_OFS: ctrl <= (ctrl & ~bmask[2:0]) | (w_data_q[2:0] & bmask[2:0]);
                `RPT_HSW_OFS: hsw <= (hsw & ~bmask[11:0]) | (w_data_q[11:0] & bmask[11:0]);
                `RPT_HBP_OFS: hbp <= (hbp & ~bmask[11:0]) | (w_data_q[11:0] & bmask[11:0]);
                `RPT_HACT_OFS: hact <= (hact & ~bmask[11:0]) | (w_data_q[11:0] & bmask[11:0]);
                `RPT_HFP_OFS: hfp <= (hfp & ~bmask[11:0]) | (w_data_q[11:0] & bmask[11:0]);
                `RPT_VSW_OFS: vsw <= (vsw & ~bmask[11:0]) | (w_data_q[11:0] & bmask[11:0]);
                `RPT_VBP_OFS: vbp <= (vbp & ~bmask[11:0]) | (w_data_q[11:0] & bmask[11:0]);
                `RPT_VACT_OFS: vact <= (vact & ~bmask[11:0]) | (w_data_q[11:0] & bmask[11:0]);
                `RPT_VFP_OFS: vfp <= (vfp & ~bmask[11:0]) | (w_data_q[11:0] & bmask[11:0]);
                `RPT_VEXTRA_OFS: vextra <= (vextra & ~bmask[11:0])
                    | (w_data_q[11:0] & bmask[11:0]); // RL4 RL12
                `RPT_DIV_OFS: begin
                    active_dot_rate <= (active_dot_rate & ~bmask[7:0])
                        | (w_data_q[7:0] & bmask[7:0]); // RL13
                    blank_dot_rate <= (blank_dot_rate & ~bmask[15:8])
                        | (w_data_q[15:8] & bmask[15:8]);
                end
                default: ;
            endcase
        end
    end

    // dot clock divider, half period is divider plus one aclk cycles
    always @(posedge aclk) begin
        if (!aresetn) begin
            half_cnt <= {`RPT_DIV_W{1'b0}};
            dot_clk_out <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                half_cnt <= {`RPT_DIV_W{1'b0}};
                dot_clk_out <= ctrl[`RPT_CTRL_INVERT];
            end else if (half_hit) begin
                half_cnt <= {`RPT_DIV_W{1'b0}};
                dot_clk_out <= !dot_clk_out;
            end else begin
                half_cnt <= half_cnt + 1'b1;
            end
        end
    end

    // position counters and panel outputs, updated on each launch edge
    always @(posedge aclk) begin
        if (!aresetn) begin
            h_cnt <= 14'h0000; // RL16
            v_cnt <= 14'h0000;
            v_act_q <= 1'b0;
            frame_count <= 16'h0000;
            line_sync_pin <= 1'b0;
            frame_sync_pin <= 1'b0;
            pixel_valid_out <= 1'b0;
            line_valid_out <= 1'b0;
            pixel_data_out <= 16'h0000;
            line_fetch_trigger <= 1'b0;
            underflow <= 1'b0;
        end else if (ce) begin
            line_fetch_trigger <= 1'b0;
            // writing one clears underflow, a new underflow wins
            if (wr_go && aw_addr_q == `RPT_STATUS_OFS && w_strb_q[2]
                    && w_data_q[`RPT_ST_UNDERFLOW]) begin
                underflow <= 1'b0;
            end
            if (!run) begin
                h_cnt <= 14'h0000;
                v_cnt <= 14'h0000;
                v_act_q <= 1'b0;
                line_sync_pin <= 1'b0;
                frame_sync_pin <= 1'b0;
                pixel_valid_out <= 1'b0;
                line_valid_out <= 1'b0;
                pixel_data_out <= 16'h0000; // RL5
            end else if (dot_tick) begin
                line_sync_pin <= (h_cnt < {2'b00, hsw}); // RL2
                frame_sync_pin <= (v_cnt < {2'b00, vsw}); // RL3
                line_valid_out <= pos_act; // RL5
                // held high when the panel runs from back porch alone
                pixel_valid_out <= pos_act || !ctrl[`RPT_CTRL_DE_USE]; // RL5 RL6 RL9
                v_act_q <= v_act;
                // red 15:11, green 10:5, blue 4:0 go to panel msbs
                pixel_data_out <= (pos_act && fifo_valid) ? fifo_data : 16'h0000; // RL1 RL7 RL8
                if (pos_act && !fifo_valid) begin
                    underflow <= 1'b1;
                end
                if (v_act && h_cnt == h_act_end) begin
                    line_fetch_trigger <= 1'b1; // RL14
                end
                if (h_cnt >= h_last) begin
                    h_cnt <= 14'h0000;
                    if (v_cnt >= v_last) begin
                        v_cnt <= 14'h0000;
                        frame_count <= frame_count + 16'h0001; // RL10
                    end else begin
                        v_cnt <= v_cnt + 14'h0001;
                    end
                end else begin
                    h_cnt <= h_cnt + 14'h0001;
                end
            end
        end
    end
endmodule // rpt_top

// ===== verif/rpt_sva.sv
// Purpose: port-level checks of the rgb panel timing block
// Assumes: single aclk domain, synchronous active-low reset
// Notes: attached to rpt_top by bind at the foot
`timescale 1ns/1ps
module rpt_sva (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // panel pins
    input wire dot_clk_out,
    input wire line_sync_pin,
    input wire frame_sync_pin,
    input wire pixel_valid_out,
    input wire line_valid_out,
    input wire [15:0] pixel_data_out,
    // status
    input wire line_fetch_trigger,
    input wire [15:0] frame_count
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // steps of a line start and a line end
    sequence s_line_start;
        $rose(line_sync_pin);
    endsequence
    sequence s_line_end;
        $fell(line_valid_out) ##1 !line_fetch_trigger;
    endsequence
    property p_reset;
        disable iff (1'b0) !aresetn |=> !line_sync_pin && !frame_sync_pin && !pixel_valid_out
            && frame_count == 16'h0000;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
    property p_launch;
        $changed(pixel_data_out) && $past(aresetn) |-> $changed(dot_clk_out);
    endproperty
    a_launch: assert property (p_launch) else $error("pixel changed off a dot edge");
    property p_blank_zero;
        !line_valid_out |-> pixel_data_out == 16'h0000;
    endproperty
    a_blank_zero: assert property (p_blank_zero) else $error("pixel data in blanking");
    property p_enable;
        line_valid_out |-> pixel_valid_out;
    endproperty
    a_enable: assert property (p_enable) else $error("enable low on active pixel");
    property p_fetch;
        line_fetch_trigger |-> s_line_end;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch pulse not at line end");
    property p_frame_start;
        $rose(frame_sync_pin) |-> s_line_start;
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("frame not on line start");
    property p_count_step;
        $changed(frame_count) && $past(aresetn) |-> frame_count == $past(frame_count) + 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("frame count step wrong");
    property p_count_pos;
        $changed(frame_count) && $past(aresetn) |-> !line_valid_out && !line_sync_pin;
    endproperty
    a_count_pos: assert property (p_count_pos) else $error("frame count not at last dot");
    property p_porch;
        $rose(line_valid_out) |-> !line_sync_pin;
    endproperty
    a_porch: assert property (p_porch) else $error("active pixel inside sync");
endmodule // rpt_sva
bind rpt_top rpt_sva u_sva (.*);

// ===== verif/rpt_panel_model.sv
// Purpose: behavioural rgb panel that latches pixels and measures timing
// Assumes: dot clock sampled by aclk
// Notes: fixed_mode locates pixels by porch counts as well as enable
`timescale 1ns/1ps
module rpt_panel_model #(
    parameter H_BP = 2,
    parameter H_ACT = 4,
    parameter V_BP = 2,
    parameter V_ACT = 2
) (
    // clock and mode
    input wire aclk,
    input wire inv,
    input wire fixed_mode,
    // panel pins
    input wire dot_clk,
    input wire hs,
    input wire vs,
    input wire de,
    input wire [15:0] rgb,
    // measurements
    output reg [11:0] line_len,
    output reg [11:0] frame_lines,
    output reg [11:0] line_pix,
    output reg [11:0] act_per,
    output reg [11:0] blank_per
);
    logic [15:0] caught[$];
    reg dprev = 0, hprev = 0, vprev = 0, was_pix = 0, pix, hrise, vrise;
    reg [11:0] d = 0, l = 0, p = 0, per = 0, di, li;
    // latch at the selected dot edge, count dots, lines and pixels
    always @(posedge aclk) begin
        dprev <= dot_clk;
        per <= per + 12'h001;
        if (dot_clk != dprev && dot_clk == !inv) begin
            hrise = hs && !hprev;
            vrise = vs && !vprev;
            di = hrise ? 12'h000 : d + 12'h001;
            li = vrise ? 12'h000 : (hrise ? l + 12'h001 : l);
            pix = de && (!fixed_mode || (di >= H_BP && di < H_BP + H_ACT
                && li >= V_BP && li < V_BP + V_ACT));
            if (pix)
                caught.push_back(rgb);
            if (pix && was_pix)
                act_per <= per;
            if (!pix && !was_pix)
                blank_per <= per;
            if (hrise) begin
                line_len <= d + 12'h001;
                if (p != 12'h000)
                    line_pix <= p;
            end
            if (vrise)
                frame_lines <= l + 12'h001;
            p <= hrise ? {11'h000, pix} : p + {11'h000, pix};
            d <= di;
            l <= li;
            was_pix <= pix;
            hprev <= hs;
            vprev <= vs;
            per <= 12'h001;
        end
    end
endmodule // rpt_panel_model

// ===== verif/tb_top.sv
// Purpose: register-driven tests of the rgb panel timing block
// Assumes: aclk 40 ns, dot period 320 ns while active
// Notes: small line and frame counts keep the run short
`timescale 1ns/1ps
`include "rpt_defs.vh"
module tb_top;
    reg aclk = 0, aresetn = 0, feed_en = 0, inv_mode = 0, fixed_mode = 0;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0;
    reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    reg [15:0] pixel_in_data = 16'h0000, f, fc_total = 16'h0000;
    reg pixel_in_valid = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pixel_in_ready;
    wire dot_clk_out, line_sync_pin, frame_sync_pin, pixel_valid_out, line_valid_out;
    wire line_fetch_trigger, transfer_active_flag;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] pixel_data_out, frame_count;
    wire [11:0] line_len, frame_lines, line_pix, act_per, blank_per;
    integer mismatches = 0, cmp_count = 0, i;
    logic [15:0] sent[$];
    // timing table: address, value (blank rate 1, active rate 3)
    localparam logic [23:0] CFG [0:8] = '{24'h040001, 24'h080001, 24'h0C0004, 24'h100002,
        24'h140001, 24'h180001, 24'h1C0002, 24'h200001, 24'h280103};
    rpt_top uut (.*, .ce(1'b1), .s_axi_wstrb(4'hF));
    rpt_panel_model pm (.aclk(aclk), .inv(inv_mode), .fixed_mode(fixed_mode),
        .dot_clk(dot_clk_out), .hs(line_sync_pin), .vs(frame_sync_pin), .de(pixel_valid_out),
        .rgb(pixel_data_out), .line_len(line_len), .frame_lines(frame_lines),
        .line_pix(line_pix), .act_per(act_per), .blank_per(blank_per));
    always #20 aclk = ~aclk;
    // pixel source: holds each word until the buffer takes it
    always @(posedge aclk) begin
        pixel_in_valid <= feed_en;
        if (pixel_in_valid && pixel_in_ready) begin
            sent.push_back(pixel_in_data);
            pixel_in_data <= pixel_in_data + 16'h0843;
        end
    end
    task complete_run;
        if (mismatches == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string what, input [31:0] exp, input [31:0] got);
        cmp_count = cmp_count + 1;
        if (exp !== got) begin
            mismatches = mismatches + 1;
            $display("unexpected %0s expected %h seen %h", what, exp, got);
        end
    endtask
    task axi_wr(input [7:0] a, input [31:0] d, input [1:0] er);
        reg aw_d, w_d;
        aw_d = 0;
        w_d = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!(aw_d && w_d)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_d = 1;
                s_axi_awvalid <= 0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_d = 1;
                s_axi_wvalid <= 0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
        chk("bresp", er, s_axi_bresp);
        @(posedge aclk);
    endtask
    task axi_rd(input [7:0] a, input [31:0] exp, input [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        s_axi_rready <= 0;
        chk("rresp", er, s_axi_rresp);
        chk("rdata", exp, s_axi_rdata);
        @(posedge aclk);
    endtask
    // run two frames, measure the link, then stop in blanking
    task run_case(input [31:0] ctrl, input inv, input fix, input [11:0] lines);
        inv_mode <= inv;
        fixed_mode <= fix;
        axi_wr(`RPT_CTRL_OFS, ctrl, `RPT_RESP_OKAY);
        repeat (2) begin
            f = frame_count;
            while (frame_count === f) @(posedge aclk);
            fc_total = fc_total + 16'h0001;
        end
        chk("line dots", 12'h008, line_len);
        chk("frame lines", lines, frame_lines);
        chk("line pixels", 12'h004, line_pix);
        chk("active period", 12'h008, act_per);
        chk("blank period", 12'h004, blank_per);
        if (fix)
            chk("enable", 1'b1, pixel_valid_out);
        axi_wr(`RPT_CTRL_OFS, ctrl & 32'hFFFFFFFE, `RPT_RESP_OKAY);
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        axi_rd(`RPT_CTRL_OFS, {29'h0, `RPT_CTRL_RST}, `RPT_RESP_OKAY);
        axi_rd(`RPT_HACT_OFS, 32'h140, `RPT_RESP_OKAY);
        axi_rd(`RPT_VACT_OFS, 32'h0F0, `RPT_RESP_OKAY);
        axi_rd(`RPT_STATUS_OFS, 32'h0, `RPT_RESP_OKAY);
        axi_rd(8'h30, 32'h0, `RPT_RESP_SLVERR);
        axi_wr(8'h34, 32'h1, `RPT_RESP_SLVERR);
        for (i = 0; i < 9; i++)
            axi_wr(CFG[i][23:16], {16'h0000, CFG[i][15:0]}, `RPT_RESP_OKAY);
        axi_rd(`RPT_HACT_OFS, 32'h4, `RPT_RESP_OKAY);
        feed_en <= 1;
        repeat (12) @(posedge aclk);
        chk("buffer level", 32'd8, sent.size());
        chk("in ready", 1'b0, pixel_in_ready);
        run_case(32'h5, 0, 0, 12'h005);
        axi_wr(`RPT_VEXTRA_OFS, 32'h3, `RPT_RESP_OKAY);
        run_case(32'h5, 0, 0, 12'h008);
        run_case(32'h7, 1, 0, 12'h008);
        run_case(32'h1, 0, 1, 12'h008);
        chk("active flag", 1'b0, transfer_active_flag);
        axi_rd(`RPT_STATUS_OFS, {16'h0000, fc_total}, `RPT_RESP_OKAY);
        chk("pixels caught", 1'b1, pm.caught.size() >= 64);
        for (i = 0; i < pm.caught.size(); i++)
            chk("pixel", sent[i], pm.caught[i]);
        axi_wr(`RPT_CTRL_OFS, 32'h5, `RPT_RESP_OKAY);
        repeat (100) @(posedge aclk);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        axi_rd(`RPT_CTRL_OFS, {29'h0, `RPT_CTRL_RST}, `RPT_RESP_OKAY);
        axi_rd(`RPT_STATUS_OFS, 32'h0, `RPT_RESP_OKAY);
        complete_run;
    end
    // watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches = mismatches + 1;
        complete_run;
    end
endmodule // tb_top
